// File: verilog/osdad_pkg.sv
// Package with register map, attribute codes and timing counts for the attribute decoder.
package osdad_pkg;
	localparam int          ADDR_W          = 2;
	localparam int          DATA_W          = 32;
	localparam int          COLS            = 40;
	localparam int          COL_W           = 6;
	localparam int          ROW_W           = 5;
	// Word-addressed register indices.
	localparam logic [1:0]  REG_CTRL        = 2'h0;
	localparam logic [1:0]  REG_DEFAULTS    = 2'h1;
	localparam logic [1:0]  REG_STATUS      = 2'h2;
	// Control register fields.
	localparam int          CTRL_SPS_BIT    = 0;
	localparam int          CTRL_FRINGE_BIT = 1;
	localparam int          CTRL_CONCEAL_BIT = 2;
	localparam int          CTRL_FONTSW_BIT = 3;
	localparam int          CTRL_LEVEL1_BIT = 4;
	localparam int          CTRL_BOXWIN_LSB = 5;
	localparam logic [7:0]  CTRL_RESET      = 8'h06;
	// Default colour register fields.
	localparam int          DEF_FG_LSB      = 0;
	localparam int          DEF_BG_LSB      = 4;
	localparam logic [6:0]  DEFAULTS_RESET  = 7'h07;
	// Status register fields.
	localparam int          ST_FLASH_LSB    = 0;
	localparam int          ST_PHASE_BIT    = 6;
	localparam int          ST_LOWER_BIT    = 7;
	localparam int          ST_SUPPR_BIT    = 8;
	// Serial attribute codes.
	localparam logic [7:0]  C_ALPHA_BASE    = 8'h00;
	localparam logic [7:0]  C_FLASH         = 8'h08;
	localparam logic [7:0]  C_STEADY        = 8'h09;
	localparam logic [7:0]  C_BOX_OFF       = 8'h0A;
	localparam logic [7:0]  C_BOX_ON        = 8'h0B;
	localparam logic [7:0]  C_NORMAL_H      = 8'h0C;
	localparam logic [7:0]  C_DOUBLE_H      = 8'h0D;
	localparam logic [7:0]  C_MOSAIC_BASE   = 8'h10;
	localparam logic [7:0]  C_CONCEAL       = 8'h18;
	localparam logic [7:0]  C_CONTIG        = 8'h19;
	localparam logic [7:0]  C_SEPARATED     = 8'h1A;
	localparam logic [7:0]  C_FRINGE        = 8'h1B;
	localparam logic [7:0]  C_BLACK_BG      = 8'h1C;
	localparam logic [7:0]  C_NEW_BG        = 8'h1D;
	localparam logic [7:0]  C_HOLD          = 8'h1E;
	localparam logic [7:0]  C_RELEASE       = 8'h1F;
	localparam logic [7:0]  C_SPACE         = 8'h20;
	// Parallel attribute byte fields.
	localparam int          PA_TYPE_BIT     = 7;
	localparam int          PA_BG_LSB       = 0;
	localparam int          PA_HI_BIT       = 3;
	localparam int          PA_FG_LSB       = 4;
	localparam int          PA_CSS_BIT      = 0;
	localparam int          PA_US_BIT       = 1;
	localparam int          PA_DH_BIT       = 2;
	localparam int          PA_DW_BIT       = 3;
	localparam int          PA_UH_BIT       = 4;
	localparam int          PA_BX_BIT       = 5;
	localparam int          PA_SR_BIT       = 6;
	// Row and flash timing.
	localparam logic [4:0]  ROW_LAST_PAGE   = 5'd23;
	localparam logic [5:0]  FLASH_ON_VS     = 6'd32;
	localparam logic [5:0]  FLASH_OFF_VS    = 6'd16;
	localparam logic [5:0]  FLASH_LAST      = 6'(FLASH_ON_VS + FLASH_OFF_VS - 6'd1);
	// Word kept per column for the lower half row: code, fg, bg, hi, flash, fringe, box,
	// font, separated, double height.
	localparam int          STORE_W         = 21;
	typedef enum logic [1:0] {OSDAD_BOX_NONE, OSDAD_BOX_ON, OSDAD_BOX_OFF} osdad_box_e;
endpackage : osdad_pkg

// File: verilog/osdad_row_store.sv
// Column store that replays the upper row's decoded characters for the lower half row.
`timescale 1ns/1ps
module osdad_row_store #(
	parameter int DEPTH = 40,
	parameter int IDX_W = 6,
	parameter int WIDTH = 21
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             wr_en_i,
	input  wire logic [IDX_W-1:0] wr_idx_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic [IDX_W-1:0] rd_idx_i,
	output logic      [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] mem_reg [DEPTH];

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_col
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					mem_reg[g] <= '0;
				end else if (wr_en_i && wr_idx_i == IDX_W'(g)) begin
					mem_reg[g] <= wr_data_i;
				end
			end
		end
	endgenerate

	// Out-of-range columns read as zero rather than wrapping onto a real column.
	assign rd_data_o = (rd_idx_i < IDX_W'(DEPTH)) ? mem_reg[rd_idx_i] : '0;
endmodule : osdad_row_store

// File: verilog/osdad_decoder.sv
// Serial and parallel attribute decoder of the on-screen display character path.
// Functional notes
// - Select bit clear gives serial attribute mode.
// - Serial attribute positions show as spaces.
// - Row defaults reload at every row start.
// - Set-at codes act now, others next.
// - Always-active codes decode in level-one mode.
// - Code 1Bh toggles fringe or second font.
// - Flash shows foreground 32 vsyncs, background 16.
// - Fringe code toggles black half-dot outline.
// - Conceal draws spaces until foreground colour.
// - Box needs two consecutive on or off.
// - Double height repeats lower halves next row.
// - Serial double height row 23 hides status.
// - Hold mosaic repeats last mosaic at attributes.
// - Select bit set gives two-byte parallel mode.
// - Parallel attribute applies to its own character.
// - Attribute MSB picks colour or shape meaning.
// - Parallel double height draws selected half only.
// - Upper-half bit honoured for top-half rows.
// - Colour byte background bits 0-2, half bit 3.
// - Parallel double height row 23 keeps status.
`timescale 1ns/1ps
module osdad_decoder (
	input  wire logic                         clk_i,
	input  wire logic                         nrst_i,
	input  wire logic [osdad_pkg::ADDR_W-1:0] avs_address_i,
	input  wire logic                         avs_read_i,
	input  wire logic                         avs_write_i,
	input  wire logic [3:0]                   avs_byteenable_i,
	input  wire logic [osdad_pkg::DATA_W-1:0] avs_writedata_i,
	output logic      [osdad_pkg::DATA_W-1:0] avs_readdata_o,
	output logic                              avs_waitrequest_o,
	input  wire logic                         vsync_i,
	input  wire logic                         row_start_i,
	input  wire logic [osdad_pkg::ROW_W-1:0]  row_i,
	input  wire logic                         char_valid_i,
	input  wire logic [7:0]                   char_code_i,
	input  wire logic [7:0]                   attr_byte_i,
	output logic                              out_valid_o,
	output logic      [7:0]                   out_code_o,
	output logic      [2:0]                   fg_o,
	output logic      [2:0]                   bg_o,
	output logic                              half_int_o,
	output logic                              fringe_o,
	output logic                              box_o,
	output logic      [2:0]                   box_window_o,
	output logic                              double_height_o,
	output logic                              upper_half_o,
	output logic                              double_width_o,
	output logic                              alt_font_o,
	output logic                              charset_ext_o,
	output logic                              separated_o,
	output logic                              rounding_o,
	output logic                              status_suppress_o
);
	import osdad_pkg::*;

	logic             rst_s1_reg, rst_n;
	logic             vs_s1_reg, vs_s2_reg, vs_s3_reg;
	logic             vs_edge;
	logic             ack_reg;
	logic             req;
	logic [7:0]       ctrl_reg;
	logic [6:0]       defaults_reg;
	logic [5:0]       flash_cnt_reg;
	logic             flash_vis;
	logic [COL_W-1:0] col_reg;
	logic             lower_row_reg, dh_row_reg, suppress_reg;
	logic [2:0]       fg_reg, bg_reg, fg_next, bg_next;
	logic             flash_reg, conceal_reg, fringe_reg, mosaic_reg, sep_reg, hold_reg;
	logic             box_reg, font_reg, dh_reg;
	logic             flash_next, conceal_next, fringe_next, mosaic_next, sep_next, hold_next;
	logic             box_next, font_next, dh_next;
	osdad_box_e       boxp_reg, boxp_next;
	logic [7:0]       held_reg, held_next;
	logic [STORE_W-1:0] word, store_rd;
	logic [2:0]       d_fg, d_bg;
	logic [7:0]       d_code;
	logic             d_hi, d_flash, d_fringe, d_box, d_font, d_sep;
	logic             d_dh, d_uh, d_dw, d_css, d_sr;
	logic             sps, is_attr;

	function automatic logic [STORE_W-1:0] pack_word(input logic [7:0] c, input logic [2:0] f,
			input logic [2:0] b, input logic [6:0] fl);
		pack_word = {c, f, b, fl};
	endfunction : pack_word

	// Reset is released through two flops so every flop leaves reset on the same edge.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			vs_s1_reg <= 1'b0;
			vs_s2_reg <= 1'b0;
			vs_s3_reg <= 1'b0;
		end else begin
			vs_s1_reg <= vsync_i;
			vs_s2_reg <= vs_s1_reg;
			vs_s3_reg <= vs_s2_reg;
		end
	end
	assign vs_edge = vs_s2_reg & ~vs_s3_reg;

	// Bus slave: one wait state; reads load on the first edge, writes land when wait drops.
	assign req               = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_reg;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg        <= 1'b0;
			avs_readdata_o <= '0;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (avs_read_i && !ack_reg) begin
				case (avs_address_i)
					REG_CTRL:     avs_readdata_o <= DATA_W'(ctrl_reg);
					REG_DEFAULTS: avs_readdata_o <= DATA_W'(defaults_reg);
					REG_STATUS:   avs_readdata_o <= DATA_W'({suppress_reg, lower_row_reg,
							flash_vis, flash_cnt_reg});
					default:      avs_readdata_o <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg     <= CTRL_RESET;
			defaults_reg <= DEFAULTS_RESET;
		end else if (avs_write_i && ack_reg && avs_byteenable_i[0]) begin
			if (avs_address_i == REG_CTRL) begin
				ctrl_reg <= avs_writedata_i[7:0];
			end
			if (avs_address_i == REG_DEFAULTS) begin
				defaults_reg <= avs_writedata_i[6:0];
			end
		end
	end
	assign sps = ctrl_reg[CTRL_SPS_BIT];

	// One frame counter for the whole screen keeps all flashing text in step.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			flash_cnt_reg <= '0;
		end else if (vs_edge) begin
			flash_cnt_reg <= (flash_cnt_reg == FLASH_LAST) ? 6'h00 : flash_cnt_reg + 6'h01;
		end
	end
	assign flash_vis = flash_cnt_reg < FLASH_ON_VS;

	// Row bookkeeping: column, lower-half row and status-row suppression.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			col_reg       <= '0;
			lower_row_reg <= 1'b0;
			dh_row_reg    <= 1'b0;
			suppress_reg  <= 1'b0;
		end else begin
			// A new frame gives the status row back, but a row-23 code in that cycle wins.
			if (vs_edge) begin
				suppress_reg <= 1'b0;
			end
			if (row_start_i) begin
				col_reg       <= '0;
				lower_row_reg <= dh_row_reg & ~lower_row_reg;
				dh_row_reg    <= 1'b0;
			end else if (char_valid_i) begin
				col_reg <= col_reg + COL_W'(1);
				if (!sps && !lower_row_reg && char_code_i == C_DOUBLE_H) begin
					dh_row_reg <= 1'b1;
					if (row_i == ROW_LAST_PAGE) begin
						suppress_reg <= 1'b1;
					end
				end
			end
		end
	end

	assign is_attr = char_code_i < C_SPACE;

	// Serial decode: d_ values shape this character, _next values the following ones.
	always_comb begin
		fg_next    = fg_reg;
		bg_next    = bg_reg;
		flash_next = flash_reg;
		conceal_next = conceal_reg;
		fringe_next = fringe_reg;
		mosaic_next = mosaic_reg;
		sep_next   = sep_reg;
		hold_next  = hold_reg;
		box_next   = box_reg;
		font_next  = font_reg;
		dh_next    = dh_reg;
		boxp_next  = OSDAD_BOX_NONE;
		held_next  = held_reg;
		if (is_attr) begin
			case (char_code_i)
				C_STEADY:    flash_next = 1'b0;
				C_NORMAL_H:  dh_next = 1'b0;
				C_CONCEAL:   conceal_next = 1'b1;
				C_CONTIG:    sep_next = 1'b0;
				C_SEPARATED: sep_next = 1'b1;
				C_BLACK_BG:  bg_next = 3'h0;
				C_NEW_BG:    bg_next = fg_reg;
				C_HOLD:      hold_next = 1'b1;
				default:     ;
			endcase
		end
		// Set-at effects already reach the attribute position itself.
		d_bg    = bg_next;
		d_flash = flash_next;
		d_sep   = sep_next;
		d_fg    = fg_reg;
		d_fringe = fringe_reg;
		d_box   = box_reg;
		d_font  = font_reg;
		d_hi    = 1'b0;
		d_dh    = dh_next;
		d_uh    = dh_next;
		d_dw    = 1'b0;
		d_css   = 1'b0;
		d_sr    = 1'b0;
		if (is_attr) begin
			d_code = hold_next ? held_reg : C_SPACE;
		end else if (conceal_next && ctrl_reg[CTRL_CONCEAL_BIT]) begin
			d_code = C_SPACE;
		end else begin
			d_code = char_code_i;
		end
		if (!is_attr && mosaic_reg) begin
			held_next = char_code_i;
		end
		if (is_attr) begin
			if (char_code_i[7:3] == C_ALPHA_BASE[7:3] || char_code_i[7:3] == C_MOSAIC_BASE[7:3]) begin
				fg_next      = char_code_i[2:0];
				mosaic_next  = char_code_i[4];
				conceal_next = 1'b0;
			end
			case (char_code_i)
				C_FLASH:    flash_next = 1'b1;
				C_BOX_ON: begin
					boxp_next = OSDAD_BOX_ON;
					if (boxp_reg == OSDAD_BOX_ON) begin
						box_next = 1'b1;
					end
				end
				C_BOX_OFF: begin
					boxp_next = OSDAD_BOX_OFF;
					if (boxp_reg == OSDAD_BOX_OFF) begin
						box_next = 1'b0;
					end
				end
				C_DOUBLE_H: dh_next = 1'b1;
				// Fringe and black-mosaic stay live in level-one text mode.
				C_FRINGE: begin
					fringe_next = fringe_reg ^ ctrl_reg[CTRL_FRINGE_BIT];
					font_next   = font_reg ^ ctrl_reg[CTRL_FONTSW_BIT];
				end
				C_RELEASE:  hold_next = 1'b0;
				default:    ;
			endcase
		end
		// Parallel mode: the attribute byte shapes only its own character.
		if (sps) begin
			d_code   = char_code_i;
			d_fg     = defaults_reg[DEF_FG_LSB +: 3];
			d_bg     = defaults_reg[DEF_BG_LSB +: 3];
			d_flash  = 1'b0;
			d_fringe = 1'b0;
			d_font   = 1'b0;
			d_box    = 1'b0;
			d_sep    = 1'b0;
			d_dh     = 1'b0;
			d_uh     = 1'b0;
			if (!attr_byte_i[PA_TYPE_BIT]) begin
				d_bg = attr_byte_i[PA_BG_LSB +: 3];
				d_hi = attr_byte_i[PA_HI_BIT];
				d_fg = attr_byte_i[PA_FG_LSB +: 3];
			end else begin
				d_css = attr_byte_i[PA_CSS_BIT];
				d_sep = attr_byte_i[PA_US_BIT];
				d_dh  = attr_byte_i[PA_DH_BIT];
				d_dw  = attr_byte_i[PA_DW_BIT];
				d_uh  = attr_byte_i[PA_DH_BIT] & attr_byte_i[PA_UH_BIT];
				d_box = attr_byte_i[PA_BX_BIT];
				d_sr  = attr_byte_i[PA_SR_BIT];
			end
		end
		word = pack_word(d_code, d_fg, d_bg,
				{d_hi, d_flash, d_fringe, d_box, d_font, d_sep, d_dh});
	end

	// Serial state: row defaults at row start, decoded updates per character.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fg_reg      <= 3'h7;
			bg_reg      <= 3'h0;
			flash_reg   <= 1'b0;
			conceal_reg <= 1'b0;
			fringe_reg  <= 1'b0;
			mosaic_reg  <= 1'b0;
			sep_reg     <= 1'b0;
			hold_reg    <= 1'b0;
			box_reg     <= 1'b0;
			font_reg    <= 1'b0;
			dh_reg      <= 1'b0;
			boxp_reg    <= OSDAD_BOX_NONE;
			held_reg    <= C_SPACE;
		end else if (row_start_i) begin
			fg_reg      <= defaults_reg[DEF_FG_LSB +: 3];
			bg_reg      <= defaults_reg[DEF_BG_LSB +: 3];
			flash_reg   <= 1'b0;
			conceal_reg <= 1'b0;
			fringe_reg  <= 1'b0;
			mosaic_reg  <= 1'b0;
			sep_reg     <= 1'b0;
			hold_reg    <= 1'b0;
			box_reg     <= 1'b0;
			font_reg    <= 1'b0;
			dh_reg      <= 1'b0;
			boxp_reg    <= OSDAD_BOX_NONE;
			held_reg    <= C_SPACE;
		end else if (char_valid_i && !sps) begin
			fg_reg      <= fg_next;
			bg_reg      <= bg_next;
			flash_reg   <= flash_next;
			conceal_reg <= conceal_next;
			fringe_reg  <= fringe_next;
			mosaic_reg  <= mosaic_next;
			sep_reg     <= sep_next;
			hold_reg    <= hold_next;
			box_reg     <= box_next;
			font_reg    <= font_next;
			dh_reg      <= dh_next;
			boxp_reg    <= boxp_next;
			held_reg    <= held_next;
		end
	end

	osdad_row_store #(
		.DEPTH(COLS),
		.IDX_W(COL_W),
		.WIDTH(STORE_W)
	) u_store (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n),
		.wr_en_i  (char_valid_i & ~lower_row_reg & ~row_start_i),
		.wr_idx_i (col_reg),
		.wr_data_i(word),
		.rd_idx_i (col_reg),
		.rd_data_o(store_rd)
	);

	// Output stage; a lower-half row replays the stored word and drops its own input.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_o     <= 1'b0;
			out_code_o      <= C_SPACE;
			fg_o            <= 3'h0;
			bg_o            <= 3'h0;
			half_int_o      <= 1'b0;
			fringe_o        <= 1'b0;
			box_o           <= 1'b0;
			box_window_o    <= 3'h0;
			double_height_o <= 1'b0;
			upper_half_o    <= 1'b0;
			double_width_o  <= 1'b0;
			alt_font_o      <= 1'b0;
			charset_ext_o   <= 1'b0;
			separated_o     <= 1'b0;
			rounding_o      <= 1'b0;
		end else begin
			out_valid_o <= char_valid_i & ~row_start_i;
			if (char_valid_i && !row_start_i) begin
				if (lower_row_reg && !sps) begin
					out_code_o      <= store_rd[20:13];
					fg_o            <= (store_rd[5] && !flash_vis) ? store_rd[9:7] : store_rd[12:10];
					bg_o            <= store_rd[9:7];
					half_int_o      <= store_rd[6];
					fringe_o        <= store_rd[4];
					box_o           <= store_rd[3] & ~ctrl_reg[CTRL_LEVEL1_BIT];
					alt_font_o      <= store_rd[2];
					separated_o     <= store_rd[1];
					double_height_o <= store_rd[0];
					upper_half_o    <= 1'b0;
					double_width_o  <= 1'b0;
					charset_ext_o   <= 1'b0;
					rounding_o      <= 1'b0;
				end else begin
					out_code_o      <= d_code;
					fg_o            <= (d_flash && !flash_vis) ? d_bg : d_fg;
					bg_o            <= d_bg;
					half_int_o      <= d_hi;
					fringe_o        <= d_fringe;
					box_o           <= d_box & (sps | ~ctrl_reg[CTRL_LEVEL1_BIT]);
					alt_font_o      <= d_font;
					separated_o     <= d_sep;
					double_height_o <= d_dh;
					upper_half_o    <= d_uh;
					double_width_o  <= d_dw;
					charset_ext_o   <= d_css;
					rounding_o      <= d_sr;
				end
			end
			box_window_o <= ctrl_reg[CTRL_BOXWIN_LSB +: 3];
		end
	end
	assign status_suppress_o = suppress_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	chk_par_bg_bits: assert property (char_valid_i && !row_start_i && sps && !attr_byte_i[7]
			|=> bg_o == $past(attr_byte_i[2:0]) && half_int_o == $past(attr_byte_i[3]))
		else $error("Parallel background or half intensity wrong.");
	chk_par_fg_bits: assert property (char_valid_i && !row_start_i && sps && !attr_byte_i[7]
			|=> fg_o == $past(attr_byte_i[6:4]))
		else $error("Parallel foreground wrong.");
	chk_attr_is_space: assert property (char_valid_i && !row_start_i && !sps && !lower_row_reg
			&& char_code_i < 8'h20 && !hold_reg && char_code_i != 8'h1E |=> out_code_o == 8'h20)
		else $error("Serial attribute not shown as space.");
	chk_flash_wrap: assert property (vs_edge && flash_cnt_reg == 6'd47 |=> flash_cnt_reg == 6'd0)
		else $error("Flash period not 48 frames.");
	chk_flash_phase: assert property (char_valid_i && !row_start_i && !sps && !lower_row_reg
			&& flash_reg && char_code_i != 8'h09 && !flash_vis |=> fg_o == bg_o)
		else $error("Flash off phase not shown in background colour.");
	chk_serial_dh_row23: assert property (char_valid_i && !row_start_i && !sps && !lower_row_reg
			&& char_code_i == 8'h0D && row_i == 5'd23 |=> status_suppress_o)
		else $error("Status row not suppressed.");
	chk_par_dh_row23: assert property (sps && !vs_edge && !status_suppress_o
			|=> !status_suppress_o)
		else $error("Parallel mode suppressed the status row.");
	chk_row_defaults: assert property (row_start_i |=> fg_reg == $past(defaults_reg[2:0])
			&& bg_reg == $past(defaults_reg[6:4]) && !flash_reg)
		else $error("Row defaults not restored.");
	chk_box_single: assert property (char_valid_i && !row_start_i && !sps
			&& char_code_i == 8'h0B && boxp_reg != OSDAD_BOX_ON && !box_reg |=> !box_reg)
		else $error("Box opened on one box-on code.");
	chk_bus_answer: assert property (req && !ack_reg |=> !avs_waitrequest_o || !req)
		else $error("Bus access not answered on second edge.");
endmodule : osdad_decoder

// File: verification/osdad_tube.sv
// Behavioural picture tube that shows each character cell's colours and blanks elsewhere.
`timescale 1ns/1ps
module osdad_tube (
	input  wire logic       blank_n_i,
	input  wire logic [2:0] fg_i,
	input  wire logic [2:0] bg_i,
	output logic      [2:0] beam_fg_o,
	output logic      [2:0] beam_bg_o
);
	// Outside a cell the beam is blanked, so stale colours never reach the screen.
	assign beam_fg_o = blank_n_i ? fg_i : 3'h0;
	assign beam_bg_o = blank_n_i ? bg_i : 3'h0;
endmodule : osdad_tube

// File: verification/osd_attribute_decoder_bench.sv
// Self-checking bench for the on-screen display attribute decoder.
`timescale 1ns/1ps
module osd_attribute_decoder_bench;
	import osdad_pkg::*;
	logic        clk_i  = 1'b0;
	logic        nrst_i = 1'b0;
	logic [1:0]  adr    = 2'h0;
	logic        rd     = 1'b0;
	logic        wr     = 1'b0;
	logic [31:0] wdata  = 32'h0;
	logic        vs     = 1'b0;
	logic        rs     = 1'b0;
	logic        cv     = 1'b0;
	logic [4:0]  row    = 5'h0;
	logic [7:0]  code   = 8'h20;
	logic [7:0]  attr   = 8'h00;
	logic [31:0] rdata;
	logic        wait_o;
	logic        ov;
	logic        hi;
	logic        sup;
	logic        fr;
	logic        bx;
	logic        dh;
	logic        uh;
	logic [2:0]  bw;
	logic [7:0]  oc;
	logic [2:0]  fg;
	logic [2:0]  bg;
	logic [2:0]  bfg;
	logic [2:0]  bbg;
	logic [14:0] q[$];
	int          n_fail      = 0;
	int          comparisons = 0;
	int          dark        = 0;
	always #12.5 clk_i = ~clk_i;
	osdad_decoder i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hF),
		.avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
		.vsync_i(vs), .row_start_i(rs), .row_i(row), .char_valid_i(cv),
		.char_code_i(code), .attr_byte_i(attr), .out_valid_o(ov), .out_code_o(oc),
		.fg_o(fg), .bg_o(bg), .half_int_o(hi), .fringe_o(fr), .box_o(bx), .box_window_o(bw),
		.double_height_o(dh), .upper_half_o(uh), .double_width_o(), .alt_font_o(),
		.charset_ext_o(), .separated_o(), .rounding_o(), .status_suppress_o(sup));
	osdad_tube i_tube (.blank_n_i(ov), .fg_i(fg), .bg_i(bg), .beam_fg_o(bfg),
		.beam_bg_o(bbg));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report
	task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d,
			input logic [31:0] exp);
		int n;
		n = 0;
		@(posedge clk_i);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wdata <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wait_o !== 1'b0 && n < 50);
		// A slave that never answers ends the run as a failure.
		if (wait_o !== 1'b0) begin
			n_fail++;
			final_report();
		end
		if (!w) check("readdata", rdata, exp);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic row_go(input logic [4:0] r);
		@(posedge clk_i);
		rs <= 1'b1;
		row <= r;
		@(posedge clk_i);
		rs <= 1'b0;
	endtask : row_go
	// A character sent with push clear is judged by the dark count, not by the queue.
	task automatic put(input logic [7:0] c, input logic [7:0] a, input logic [14:0] exp,
			input logic push);
		@(posedge clk_i);
		cv <= 1'b1;
		code <= c;
		attr <= a;
		if (push) q.push_back(exp);
		@(posedge clk_i);
		cv <= 1'b0;
	endtask : put
	function automatic logic [14:0] e(input logic [7:0] c, input logic [2:0] f,
			input logic [2:0] b, input logic h);
		return {c, f, b, h};
	endfunction : e
	always @(posedge clk_i) begin
		if (ov === 1'b1) begin
			if (q.size() == 0) begin
				if (bfg === bbg) dark++;
			end else check("pixel", 32'({oc, bfg, bbg, hi}), 32'(q.pop_front()));
		end
	end
	initial begin
		repeat (10000) @(posedge clk_i);
		n_fail++;
		final_report();
	end
	initial begin
		logic [7:0] a;
		int unsigned s;
		s = $urandom(24357);
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		bus(1'b0, REG_CTRL, 32'h0, 32'h6);
		bus(1'b0, REG_DEFAULTS, 32'h0, 32'h7);
		bus(1'b1, 2'h3, 32'hFF, 32'h0);
		bus(1'b0, 2'h3, 32'h0, 32'h0);
		row_go(5'd1);
		put(8'h01, 8'h00, e(C_SPACE, 3'h7, 3'h0, 1'b0), 1'b1);
		put(8'h41, 8'h00, e(8'h41, 3'h1, 3'h0, 1'b0), 1'b1);
		put(C_CONCEAL, 8'h00, e(C_SPACE, 3'h1, 3'h0, 1'b0), 1'b1);
		put(8'h41, 8'h00, e(C_SPACE, 3'h1, 3'h0, 1'b0), 1'b1);
		put(8'h02, 8'h00, e(C_SPACE, 3'h1, 3'h0, 1'b0), 1'b1);
		put(8'h42, 8'h00, e(8'h42, 3'h2, 3'h0, 1'b0), 1'b1);
		put(8'h11, 8'h00, e(C_SPACE, 3'h2, 3'h0, 1'b0), 1'b1);
		put(8'h6A, 8'h00, e(8'h6A, 3'h1, 3'h0, 1'b0), 1'b1);
		put(C_HOLD, 8'h00, e(8'h6A, 3'h1, 3'h0, 1'b0), 1'b1);
		row_go(5'd2);
		put(8'h41, 8'h00, e(8'h41, 3'h7, 3'h0, 1'b0), 1'b1);
		put(C_BOX_ON, 8'h00, e(C_SPACE, 3'h7, 3'h0, 1'b0), 1'b1);
		put(C_BOX_ON, 8'h00, e(C_SPACE, 3'h7, 3'h0, 1'b0), 1'b1);
		put(C_FRINGE, 8'h00, e(C_SPACE, 3'h7, 3'h0, 1'b0), 1'b1);
		put(8'h41, 8'h00, e(8'h41, 3'h7, 3'h0, 1'b0), 1'b1);
		repeat (2) @(posedge clk_i);
		check("box", 32'(bx), 32'h1);
		check("fringe", 32'(fr), 32'h1);
		bus(1'b1, REG_CTRL, 32'hA7, 32'h0);
		bus(1'b0, REG_CTRL, 32'h0, 32'hA7);
		check("window", 32'(bw), 32'h5);
		row_go(5'd3);
		repeat (6) begin
			a = 8'($urandom) & 8'h7F;
			put(8'h41, a, e(8'h41, a[6:4], a[2:0], a[3]), 1'b1);
		end
		put(8'h42, 8'h88, e(8'h42, 3'h7, 3'h0, 1'b0), 1'b1);
		row_go(5'd23);
		put(8'h43, 8'h84, e(8'h43, 3'h7, 3'h0, 1'b0), 1'b1);
		repeat (3) @(posedge clk_i);
		check("suppress", 32'(sup), 32'h0);
		check("dheight", 32'(dh), 32'h1);
		check("uhalf", 32'(uh), 32'h0);
		put(8'h44, 8'h94, e(8'h44, 3'h7, 3'h0, 1'b0), 1'b1);
		repeat (2) @(posedge clk_i);
		check("uhalf", 32'(uh), 32'h1);
		bus(1'b1, REG_CTRL, 32'h6, 32'h0);
		// One vertical sync before each flashing character samples 96 counter steps.
		repeat (96) begin
			vs <= 1'b1;
			repeat (4) @(posedge clk_i);
			vs <= 1'b0;
			repeat (4) @(posedge clk_i);
			row_go(5'd4);
			put(C_FLASH, 8'h00, e(C_SPACE, 3'h7, 3'h0, 1'b0), 1'b1);
			put(8'h41, 8'h00, 15'h0, 1'b0);
		end
		repeat (3) @(posedge clk_i);
		check("dark", 32'(dark), 32'd32);
		bus(1'b0, REG_STATUS, 32'h0, 32'h40);
		row_go(5'd23);
		put(C_DOUBLE_H, 8'h00, e(C_SPACE, 3'h7, 3'h0, 1'b0), 1'b1);
		put(8'h41, 8'h00, e(8'h41, 3'h7, 3'h0, 1'b0), 1'b1);
		repeat (3) @(posedge clk_i);
		check("suppress", 32'(sup), 32'h1);
		vs <= 1'b1;
		repeat (6) @(posedge clk_i);
		vs <= 1'b0;
		check("suppress", 32'(sup), 32'h0);
		// The row after a double height row replays the stored upper row, not its own input.
		row_go(5'd24);
		put(8'h5A, 8'h00, e(C_SPACE, 3'h7, 3'h0, 1'b0), 1'b1);
		put(8'h5A, 8'h00, e(8'h41, 3'h7, 3'h0, 1'b0), 1'b1);
		repeat (3) @(posedge clk_i);
		check("pending", 32'(q.size()), 32'h0);
		final_report();
	end
endmodule : osd_attribute_decoder_bench
